/* File: rtl/opd_decoder.sv */
// Registered opcode decoder for an 8-bit accumulator core.
// Assumes opcode and flags come from logic on the core clock, sampled when i_valid.
`timescale 1ns/1ps

// What this block does
// - Register fields decode B..L as 000..101, A as 111; 110 means memory byte.
// - Conditional instructions take 6 states if not taken, 12 if taken.
// - 11ccc000 is conditional return; codes for nonzero, positive, minus, parity tests.
// - 10ooosss is accumulator operation ooo with source register sss.
// - 11ooo110 performs the same eight operations on a following immediate byte.
// - Source field 110 in 10ooosss accumulator operations fetches the operand from memory.
// - Add-with-carry uses carry flag as input; plain add ignores it.
// - Subtract-with-borrow subtracts carry too; plain subtract does not use it.
// - 00ooo111 are rotates, decimal adjust, complement, set and invert carry.
// - Rotates via carry take carry in as rot_fill; rot_carry_out stays 0; plain rotates wrap the bit.
module opd_decoder (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire opd_pkg::opd_in_type i_data,
    output opd_pkg::opd_out_type o_dec
);
    import opd_pkg::*;

    opd_out_type state_reg;
    opd_out_type state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Condition test
    function automatic logic cond_met(input logic [2:0] cc, input opd_in_type f);
        logic r;
        r = 1'b0;
        case (cc)
            CC_NONZERO: r = !f.zero;
            CC_ZERO: r = f.zero;
            CC_NOCARRY: r = !f.carry;
            CC_CARRY: r = f.carry;
            CC_PAR_ODD: r = !f.parity;
            CC_PAR_EVEN: r = f.parity;
            CC_POSITIVE: r = !f.sign;
            default: r = f.sign;
        endcase
        return r;
    endfunction

    // Major group and low field match
    function automatic logic in_group(input logic [7:0] o, input logic [1:0] hi,
        input logic [2:0] lo);
        return o[7:6] == hi && o[2:0] == lo;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    always_comb begin
        logic [7:0] op;
        logic [2:0] mid;
        logic [2:0] low;
        op = i_data.opcode;
        mid = op[DEST_LSB +: 3];
        low = op[SRC_LSB +: 3];
        state_next = state_reg;
        if (i_valid) begin
            state_next = '0;
            state_next.op_class = CLS_NONE;
            state_next.valid = 1'b1;
            state_next.dest_reg_field = mid;
            state_next.src_reg_field = low;
            state_next.cond_code = mid;
            if (op == OP_INTERRUPTS_ON) begin
                state_next.op_class = CLS_CONTROL;
                state_next.interrupts_on = 1'b1;
            end else if (op == OP_INTERRUPTS_OFF) begin
                state_next.op_class = CLS_CONTROL;
                state_next.interrupts_off = 1'b1;
            end else if (op == OP_IDLE) begin
                state_next.op_class = CLS_CONTROL;
                state_next.idle_opcode = 1'b1;
            end else if (op == OP_STOP) begin
                state_next.op_class = CLS_CONTROL;
                state_next.stop_execution = 1'b1;
            end else if (op == OP_MASK_READ) begin
                state_next.op_class = CLS_MASK;
                state_next.interrupt_mask_read = 1'b1;
            end else if (op == OP_MASK_WRITE) begin
                state_next.op_class = CLS_MASK;
                state_next.interrupt_mask_write = 1'b1;
            end else if (op == OP_PORT_IN) begin
                state_next.op_class = CLS_PORT_IN;
            end else if (op == OP_PORT_OUT) begin
                state_next.op_class = CLS_PORT_OUT;
            end else if (in_group(op, 2'h3, 3'h0)) begin
                state_next.op_class = CLS_RET_COND;
                state_next.cond_taken = cond_met(mid, i_data);
                state_next.states = state_next.cond_taken ? COND_LONG_STATES
                                                          : COND_SHORT_STATES;
            end else if (in_group(op, 2'h3, 3'h7)) begin
                state_next.op_class = CLS_RESTART;
                state_next.restart_vector = {2'h0, mid, 3'h0};
            end else if (in_group(op, 2'h3, 3'h6)) begin
                state_next.op_class = CLS_ALU_IMM;
                state_next.alu_op = mid;
                state_next.imm_operand = 1'b1;
            end else if (op[7:6] == 2'h2) begin
                state_next.op_class = CLS_ALU_REG;
                state_next.alu_op = mid;
                state_next.mem_operand = (low == REG_MEM);
            end else if (in_group(op, 2'h0, 3'h4)) begin
                state_next.op_class = CLS_INC;
                state_next.mem_operand = (mid == REG_MEM);
            end else if (in_group(op, 2'h0, 3'h5)) begin
                state_next.op_class = CLS_DEC;
                state_next.mem_operand = (mid == REG_MEM);
            end else if (in_group(op, 2'h0, 3'h7)) begin
                state_next.op_class = CLS_ACC_SPECIAL;
                state_next.special_op = mid;
                if (mid == SP_ROT_LEFT_CY || mid == SP_ROT_RIGHT_CY) begin
                    state_next.carry_used = 1'b1;
                    state_next.rot_fill = i_data.carry;
                end
            end
            if (state_next.op_class == CLS_ALU_REG || state_next.op_class == CLS_ALU_IMM) begin
                state_next.carry_used = (mid == ALU_ADC || mid == ALU_SUB_BORROW);
                state_next.carry_in = state_next.carry_used & i_data.carry;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '{op_class: CLS_NONE, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_dec = state_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on operand fields and groups
    a_dest_field: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid |=> o_dec.dest_reg_field == $past(i_data.opcode[5:3]) &&
            o_dec.src_reg_field == $past(i_data.opcode[2:0]))
        else $error("operand field decode wrong");
    a_inc_memory: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h34 |=> o_dec.op_class == CLS_INC && o_dec.mem_operand)
        else $error("memory increment decode wrong");
    a_mem_source: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode[7:6] == 2'h2 |=>
            o_dec.mem_operand == ($past(i_data.opcode[2:0]) == 3'h6))
        else $error("memory source decode wrong");
    a_imm_source: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'hfe |=> o_dec.imm_operand && !o_dec.mem_operand)
        else $error("immediate source decode wrong");
    a_cond_states: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'he8 |=>
            o_dec.states == ($past(i_data.parity) ? COND_LONG_STATES : COND_SHORT_STATES))
        else $error("conditional duration wrong");
    a_ret_decode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'hc0 && !i_data.zero |=>
            o_dec.op_class == CLS_RET_COND && o_dec.cond_taken)
        else $error("return on nonzero wrong");
    a_ret_parity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'he0 |=>
            o_dec.op_class == CLS_RET_COND && o_dec.cond_taken == !$past(i_data.parity))
        else $error("return on parity odd wrong");
    a_ret_minus: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'hf8 |=> o_dec.cond_taken == $past(i_data.sign))
        else $error("return on minus wrong");
    a_alu_reg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode[7:6] == 2'h2 |=>
            o_dec.op_class == CLS_ALU_REG && o_dec.alu_op == $past(i_data.opcode[5:3]))
        else $error("register alu decode wrong");
    a_alu_imm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode[7:6] == 2'h3 && i_data.opcode[2:0] == 3'h6 |=>
            o_dec.op_class == CLS_ALU_IMM && o_dec.imm_operand &&
            o_dec.alu_op == $past(i_data.opcode[5:3]))
        else $error("immediate alu decode wrong");
    a_carry_plain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h81 && i_data.carry |=> !o_dec.carry_in && !o_dec.carry_used)
        else $error("plain add uses carry");
    a_imm_carry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'hce |=>
            o_dec.carry_used && o_dec.carry_in == $past(i_data.carry))
        else $error("immediate add with carry wrong");
    a_borrow_use: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h99 && i_data.carry |=> o_dec.carry_in)
        else $error("borrow not used");
    a_sub_plain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'hd6 |=> !o_dec.carry_in && !o_dec.carry_used)
        else $error("plain subtract uses carry");
    a_special_op: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode[7:6] == 2'h0 && i_data.opcode[2:0] == 3'h7 |=>
            o_dec.op_class == CLS_ACC_SPECIAL && o_dec.special_op == $past(i_data.opcode[5:3]))
        else $error("accumulator special decode wrong");
    a_rot_carry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h17 |=>
            o_dec.rot_fill == $past(i_data.carry) && o_dec.special_op == SP_ROT_LEFT_CY)
        else $error("rotate via carry fill wrong");
    a_rot_right: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h1f |=>
            o_dec.rot_fill == $past(i_data.carry) && o_dec.carry_used)
        else $error("rotate right via carry wrong");
    a_rot_plain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h07 |=> !o_dec.rot_fill && !o_dec.carry_used)
        else $error("plain rotate uses carry");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on fixed codes, restart vector and register decrement
    a_fixed_halt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h76 |=> o_dec.stop_execution && !o_dec.interrupts_on)
        else $error("halt decode wrong");
    a_fixed_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'hfb |=> o_dec.interrupts_on && o_dec.op_class == CLS_CONTROL)
        else $error("interrupt enable decode wrong");
    a_idle_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h00 |=>
            o_dec.idle_opcode && o_dec.op_class == CLS_CONTROL && !o_dec.stop_execution)
        else $error("idle decode wrong");
    a_mask_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h30 |=>
            o_dec.interrupt_mask_write && !o_dec.interrupt_mask_read && o_dec.op_class == CLS_MASK)
        else $error("mask write decode wrong");
    a_restart_vec: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'hef |=> o_dec.restart_vector == 8'h28)
        else $error("restart vector wrong");
    a_port_dirs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && (i_data.opcode == 8'hdb || i_data.opcode == 8'hd3) |=>
            o_dec.op_class == ($past(i_data.opcode[3]) ? CLS_PORT_IN : CLS_PORT_OUT))
        else $error("port direction decode wrong");
    a_dec_register: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_valid && i_data.opcode == 8'h0d |=> o_dec.op_class == CLS_DEC && !o_dec.mem_operand)
        else $error("register decrement decode wrong");

endmodule // opd_decoder

/* File: rtl/opd_pkg.sv */
// Opcode decoder package: field layouts, opcode values, class and operation codes, timing.
// Assumes a single core clock; no software-visible registers.
package opd_pkg;

    localparam int OPD_DATA_W = 8;
    // Register operand codes
    localparam logic [2:0] REG_B = 3'h0;
    localparam logic [2:0] REG_C = 3'h1;
    localparam logic [2:0] REG_D = 3'h2;
    localparam logic [2:0] REG_E = 3'h3;
    localparam logic [2:0] REG_H = 3'h4;
    localparam logic [2:0] REG_L = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A = 3'h7;
    // Field positions
    localparam int DEST_LSB = 3;
    localparam int SRC_LSB = 0;
    // Conditional return condition codes
    localparam logic [2:0] CC_NONZERO = 3'h0;
    localparam logic [2:0] CC_ZERO = 3'h1;
    localparam logic [2:0] CC_NOCARRY = 3'h2;
    localparam logic [2:0] CC_CARRY = 3'h3;
    localparam logic [2:0] CC_PAR_ODD = 3'h4;
    localparam logic [2:0] CC_PAR_EVEN = 3'h5;
    localparam logic [2:0] CC_POSITIVE = 3'h6;
    localparam logic [2:0] CC_MINUS = 3'h7;
    // Accumulator operation codes
    localparam logic [2:0] ALU_ADD = 3'h0;
    localparam logic [2:0] ALU_ADC = 3'h1;
    localparam logic [2:0] ALU_SUB = 3'h2;
    localparam logic [2:0] ALU_SUB_BORROW = 3'h3;
    localparam logic [2:0] ALU_AND = 3'h4;
    localparam logic [2:0] ALU_XOR = 3'h5;
    localparam logic [2:0] ALU_OR = 3'h6;
    localparam logic [2:0] ALU_COMPARE = 3'h7;
    // Accumulator special codes
    localparam logic [2:0] SP_ROT_LEFT = 3'h0;
    localparam logic [2:0] SP_ROT_RIGHT = 3'h1;
    localparam logic [2:0] SP_ROT_LEFT_CY = 3'h2;
    localparam logic [2:0] SP_ROT_RIGHT_CY = 3'h3;
    localparam logic [2:0] SP_DEC_ADJ = 3'h4;
    localparam logic [2:0] SP_INVERT = 3'h5;
    localparam logic [2:0] SP_SET_CY = 3'h6;
    localparam logic [2:0] SP_INV_CY = 3'h7;
    // Fixed opcodes
    localparam logic [7:0] OP_INTERRUPTS_ON = 8'hfb;
    localparam logic [7:0] OP_INTERRUPTS_OFF = 8'hf3;
    localparam logic [7:0] OP_IDLE = 8'h00;
    localparam logic [7:0] OP_STOP = 8'h76;
    localparam logic [7:0] OP_MASK_READ = 8'h20;
    localparam logic [7:0] OP_MASK_WRITE = 8'h30;
    localparam logic [7:0] OP_PORT_IN = 8'hdb;
    localparam logic [7:0] OP_PORT_OUT = 8'hd3;
    // Conditional durations in states
    localparam logic [3:0] COND_SHORT_STATES = 4'h6;
    localparam logic [3:0] COND_LONG_STATES = 4'hc;
    localparam logic [7:0] RESET_OPCODE = 8'h00;

    typedef enum logic [11:0] {
        CLS_NONE = 12'h001,
        CLS_RET_COND = 12'h002,
        CLS_RESTART = 12'h004,
        CLS_PORT_IN = 12'h008,
        CLS_PORT_OUT = 12'h010,
        CLS_INC = 12'h020,
        CLS_DEC = 12'h040,
        CLS_ALU_REG = 12'h080,
        CLS_ALU_IMM = 12'h100,
        CLS_ACC_SPECIAL = 12'h200,
        CLS_CONTROL = 12'h400,
        CLS_MASK = 12'h800
    } opd_class_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic sign;
        logic zero;
        logic parity;
        logic carry;
    } opd_in_type;

    typedef struct packed {
        opd_class_type op_class;
        logic [2:0] alu_op;
        logic [2:0] special_op;
        logic [2:0] src_reg_field;
        logic [2:0] dest_reg_field;
        logic mem_operand;
        logic imm_operand;
        logic carry_in;
        logic carry_used;
        logic [2:0] cond_code;
        logic cond_taken;
        logic [3:0] states;
        logic [7:0] restart_vector;
        logic interrupts_on;
        logic interrupts_off;
        logic idle_opcode;
        logic stop_execution;
        logic interrupt_mask_read;
        logic interrupt_mask_write;
        logic rot_fill;
        logic rot_carry_out;
        logic valid;
    } opd_out_type;

endpackage

/* File: test/tb.sv */
// Self-checking bench for the registered opcode decoder.
// Assumes opd_pkg and opd_decoder are compiled first; drives ports directly.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb;
    import opd_pkg::*;
    logic i_clk;
    logic i_rst_n;
    logic i_valid;
    opd_in_type i_data;
    opd_out_type o_dec;
    int n_mismatch = 0;
    int comparisons = 0;

    opd_decoder opd_decoder_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
        .i_data(i_data), .o_dec(o_dec));

    ////////////////////////////////////////////////////////////////////////////////
    // Drivers
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Flags are {sign, zero, parity, carry}; valid stays high for back-to-back use
    task automatic dec(input logic [7:0] op, input logic [3:0] f);
        i_valid = 1'b1;
        i_data = {op, f};
        @(posedge i_clk);
        #1;
    endtask

    task automatic idle();
        i_valid = 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_cond_return();
        logic [2:0] cc;
        logic [3:0] f;
        logic t;
        for (int i = 0; i < 8; i++) begin
            cc = i[2:0];
            for (int k = 0; k < 2; k++) begin
                f = k ? 4'ha : 4'h5;
                case (cc)
                    3'h0: t = !f[2];
                    3'h1: t = f[2];
                    3'h2: t = !f[0];
                    3'h3: t = f[0];
                    3'h4: t = !f[1];
                    3'h5: t = f[1];
                    3'h6: t = !f[3];
                    default: t = f[3];
                endcase
                dec({2'b11, cc, 3'b000}, f);
                `CHK("valid", 1'b1, o_dec.valid);
                `CHK("op_class", CLS_RET_COND, o_dec.op_class);
                `CHK("cond_code", cc, o_dec.cond_code);
                `CHK("cond_taken", t, o_dec.cond_taken);
                `CHK("states", t ? COND_LONG_STATES : COND_SHORT_STATES, o_dec.states);
            end
        end
        idle();
    endtask

    task automatic t_alu_reg();
        for (int o = 0; o < 8; o++) begin
            for (int s = 0; s < 8; s++) begin
                dec({2'b10, o[2:0], s[2:0]}, {3'b000, s[0]});
                `CHK("op_class", CLS_ALU_REG, o_dec.op_class);
                `CHK("alu_op", o[2:0], o_dec.alu_op);
                `CHK("src_reg_field", s[2:0], o_dec.src_reg_field);
                `CHK("mem_operand", s == 6, o_dec.mem_operand);
                `CHK("carry_in", s[0] & (o == 1 || o == 3), o_dec.carry_in);
                `CHK("carry_used", o == 1 || o == 3, o_dec.carry_used);
            end
        end
        idle();
    endtask

    task automatic t_alu_imm();
        for (int o = 0; o < 8; o++) begin
            dec({2'b11, o[2:0], 3'b110}, 4'h1);
            `CHK("op_class", CLS_ALU_IMM, o_dec.op_class);
            `CHK("alu_op", o[2:0], o_dec.alu_op);
            `CHK("imm_operand", 1'b1, o_dec.imm_operand);
            `CHK("carry_in", o == 1 || o == 3, o_dec.carry_in);
        end
        idle();
    endtask

    task automatic t_special();
        for (int o = 0; o < 8; o++) begin
            for (int c = 0; c < 2; c++) begin
                dec({2'b00, o[2:0], 3'b111}, {3'b000, c[0]});
                `CHK("op_class", CLS_ACC_SPECIAL, o_dec.op_class);
                `CHK("special_op", o[2:0], o_dec.special_op);
                `CHK("carry_used", o == 2 || o == 3, o_dec.carry_used);
                if (o < 4)
                    `CHK("rot_fill", (o == 2 || o == 3) & c[0], o_dec.rot_fill);
            end
        end
        idle();
    endtask

    task automatic t_fixed_and_groups();
        logic [7:0] ops [6] = '{OP_INTERRUPTS_ON, OP_INTERRUPTS_OFF, OP_IDLE, OP_STOP,
            OP_MASK_READ, OP_MASK_WRITE};
        for (int i = 0; i < 6; i++) begin
            dec(ops[i], 4'h0);
            `CHK("fixed_flags", 6'h20 >> i, {o_dec.interrupts_on, o_dec.interrupts_off,
                o_dec.idle_opcode, o_dec.stop_execution, o_dec.interrupt_mask_read,
                o_dec.interrupt_mask_write});
        end
        for (int a = 0; a < 8; a++) begin
            dec({2'b11, a[2:0], 3'b111}, 4'h0);
            `CHK("op_class", CLS_RESTART, o_dec.op_class);
            `CHK("restart_vector", {2'b00, a[2:0], 3'b000}, o_dec.restart_vector);
            dec({2'b00, a[2:0], 3'b100}, 4'h0);
            `CHK("op_class", CLS_INC, o_dec.op_class);
            `CHK("dest_reg_field", a[2:0], o_dec.dest_reg_field);
            `CHK("mem_operand", a == 6, o_dec.mem_operand);
            dec({2'b00, a[2:0], 3'b101}, 4'h0);
            `CHK("op_class", CLS_DEC, o_dec.op_class);
        end
        dec(OP_PORT_IN, 4'h0);
        `CHK("op_class", CLS_PORT_IN, o_dec.op_class);
        dec(OP_PORT_OUT, 4'h0);
        `CHK("op_class", CLS_PORT_OUT, o_dec.op_class);
        idle();
    endtask

    task automatic t_hold_and_reset();
        dec(OP_STOP, 4'h0);
        repeat (3) idle();
        `CHK("stop_held", 1'b1, o_dec.stop_execution);
        i_rst_n = 1'b0;
        idle();
        `CHK("valid_in_reset", 1'b0, o_dec.valid);
        `CHK("class_in_reset", CLS_NONE, o_dec.op_class);
        `CHK("stop_in_reset", 1'b0, o_dec.stop_execution);
        repeat (2) idle();
        i_rst_n = 1'b1;
        idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        i_rst_n = 1'b0;
        i_valid = 1'b0;
        i_data = '0;
        repeat (3) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        `CHK("valid_after_reset", 1'b0, o_dec.valid);
        t_cond_return();
        t_alu_reg();
        t_alu_imm();
        t_special();
        t_fixed_and_groups();
        t_hold_and_reset();
        t_alu_imm();
        close_out();
    end
endmodule // tb
